// ### core/prl_pkg.sv
// shared constants and types of the parallel ram boot loader
package prl_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int START_CYCLES    = 49;
  localparam int JUMP_LIMIT_CYC  = 68;
  // extra edges a pin level needs to cross the synchroniser
  localparam int PIN_SYNC_CYC    = 3;
  localparam int FLASH_HALF_MS   = 167;
  localparam int FLASH_HALF_CYC  = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RAM_ENTRY_ADDR = 16'h0050;
  localparam logic [15:0] RAM_LAST_ADDR  = 16'h00ff;
  localparam int          SRC_ADDR_W     = 14;
  localparam int          SRC_LOW_W      = 8;
  localparam logic [7:0]  SRC_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // pin bundle bit positions (synchronised group)
  // ---------------------------------------------------------------
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_HS_BIT   = 8;
  localparam int PIN_STOP_BIT = 9;
  localparam int PIN_LOCK_BIT = 10;
  localparam int PIN_W        = 11;

  typedef enum logic [2:0] {
    PRL_ST_START,
    PRL_ST_LOCKED,
    PRL_ST_POLL,
    PRL_ST_WAIT_ACK,
    PRL_ST_RELEASE,
    PRL_ST_JUMP,
    PRL_ST_DONE
  } prl_state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } prl_ram_wr_t;

endpackage : prl_pkg

// ### core/prl_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module prl_sync3 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_in,  // core clock
  input  wire logic         reset_n_in,   // async reset, active low
  input  wire logic         clk_en_in,    // clock enable
  input  wire logic [W-1:0] async_in,     // raw pin levels
  output logic      [W-1:0] stable_out    // filtered levels
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_nxt;

  // per bit: accept a change once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      stable_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : stable_out[i];
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_r       <= '0;
      s2_r       <= '0;
      s3_r       <= '0;
      stable_out <= '0;
    end else if (clk_en_in) begin
      s1_r       <= async_in;
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      stable_out <= stable_nxt;
    end
  end
endmodule : prl_sync3

// ### core/prl_ram_boot_loader.sv
// parallel ram boot loader: fills ram from a byte-wide source, then jumps
//
// Behaviour
// - on entry check lock bit; low means no loading and red indicator flashes.
// - lock inactive: fetch source bytes one by one and write each into ram.
// - before each byte sample stop input; low or ram full ends load, jump 0050.
// - each byte is paced by handshake output and handshake input.
// - loaded program raising rom disable deselects the external eprom.
// - address outputs above the low byte stay at zero.
// - red and green indicators stay off while loading ram.
// - data taken on byte port, 14-bit source address presented on outputs.
`timescale 1ns/1ns
module prl_ram_boot_loader
  import prl_pkg::*;
#(
  parameter int FLASH_HALF = prl_pkg::FLASH_HALF_CYC
) (
  input  wire logic                      core_clk_in,          // 100 MHz clock
  input  wire logic                      reset_n_in,           // async reset, active low
  input  wire logic                      clk_en_in,            // clock enable
  input  wire logic                      security_lock_bit_in, // lock strap, low = locked
  input  wire logic                      loader_stop_pin_in,   // stop pin, low = stop
  input  wire logic                      handshake_input_in,   // source ready pin
  input  wire logic [7:0]                data_port_in,         // byte-wide source data
  input  wire logic                      user_rom_disable_in,  // from loaded program
  output logic                           handshake_output_out, // byte request
  output logic [prl_pkg::SRC_ADDR_W-1:0] src_addr_out,         // source address
  output logic                           external_rom_disable_out, // high deselects eprom
  output prl_pkg::prl_ram_wr_t           ram_wr_out,           // ram write port
  output logic                           red_led_out,          // red indicator
  output logic                           green_led_out,        // green indicator
  output logic                           jump_out,             // one-cycle jump pulse
  output logic [15:0]                    jump_addr_out,        // jump target
  output logic                           loading_out           // loader busy
);
  import prl_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  // bundle order must match the bit positions in the package
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;

  assign pins_raw = {security_lock_bit_in, loader_stop_pin_in,
                     handshake_input_in, data_port_in};

  // levels pass the agreement filter, so a one-edge glitch is ignored
  // data rides with the handshake so both arrive with equal latency
  prl_sync3 #(.W(PIN_W)) u_sync (
    .core_clk_in (core_clk_in),
    .reset_n_in  (reset_n_in),
    .clk_en_in   (clk_en_in),
    .async_in    (pins_raw),
    .stable_out  (pins_s)
  );

  logic       lock_free;
  logic       stop_high;
  logic       hs_in;
  logic [7:0] data_s;

  assign lock_free = pins_s[PIN_LOCK_BIT];
  assign stop_high = pins_s[PIN_STOP_BIT];
  assign hs_in     = pins_s[PIN_HS_BIT];
  assign data_s    = pins_s[PIN_DATA_LSB +: 8];

  // ---------------------------------------------------------------
  // loader state
  // ---------------------------------------------------------------
  prl_state_t               state_r, state_nxt;
  logic [7:0]               start_cnt_r, start_cnt_nxt;
  logic [SRC_LOW_W-1:0]     src_r, src_nxt;
  logic [15:0]              ram_addr_r, ram_addr_nxt;
  logic                     ram_full_r, ram_full_nxt;
  prl_ram_wr_t              wr_r, wr_nxt;
  logic                     hs_out_r, hs_out_nxt;
  logic                     jump_r, jump_nxt;
  // wide enough for the default half period of the red flash
  logic [24:0]              flash_cnt_r, flash_cnt_nxt;
  logic                     red_r, red_nxt;
  logic                     rom_dis_r, rom_dis_nxt;

  always_comb begin
    state_nxt     = state_r;
    start_cnt_nxt = start_cnt_r;
    src_nxt       = src_r;
    ram_addr_nxt  = ram_addr_r;
    ram_full_nxt  = ram_full_r;
    wr_nxt        = wr_r;
    // address and data of the last write are kept; only the strobe drops
    wr_nxt.we     = 1'b0;
    hs_out_nxt    = hs_out_r;
    jump_nxt      = 1'b0;
    flash_cnt_nxt = flash_cnt_r;
    red_nxt       = red_r;
    // rom deselect
    // ignored before the jump: the loader still needs the eprom then
    rom_dis_nxt   = (state_r == PRL_ST_DONE) ? user_rom_disable_in : 1'b0;

    case (state_r)
      PRL_ST_START: begin
        // first stop sample after start window
        // the window runs past the jump limit plus pin latency, so a stop
        // level set just before the limit still stops the very first byte
        if (start_cnt_r == 8'(JUMP_LIMIT_CYC + PIN_SYNC_CYC - 1)) begin
          if (!lock_free) begin
            state_nxt = PRL_ST_LOCKED;
          end else begin
            state_nxt = PRL_ST_POLL;
          end
        end else begin
          start_cnt_nxt = start_cnt_r + 8'h01;
        end
      end
      PRL_ST_LOCKED: begin
        // flash red, never load
        // locked is left only by reset
        if (flash_cnt_r == 25'(FLASH_HALF - 1)) begin
          flash_cnt_nxt = 25'h0000000;
          red_nxt       = ~red_r;
        end else begin
          flash_cnt_nxt = flash_cnt_r + 25'h0000001;
        end
      end
      PRL_ST_POLL: begin
        // stop low or ram full ends load
        if (!stop_high || ram_full_r) begin
          state_nxt = PRL_ST_JUMP;
        end else if (!hs_in) begin
          // a new request only once the last answer was seen low
          // raise request, wait for source
          hs_out_nxt = 1'b1;
          state_nxt  = PRL_ST_WAIT_ACK;
        end
      end
      PRL_ST_WAIT_ACK: begin
        if (hs_in) begin
          // byte crossed the synchroniser with the answer, so it is settled
          // write byte into ram
          wr_nxt.we   = 1'b1;
          wr_nxt.addr = ram_addr_r;
          wr_nxt.data = data_s;
          hs_out_nxt  = 1'b0;
          state_nxt   = PRL_ST_RELEASE;
        end
      end
      PRL_ST_RELEASE: begin
        if (!hs_in) begin
          src_nxt = src_r + SRC_LOW_W'(1);
          if (ram_addr_r == RAM_LAST_ADDR) begin
            // full is only set; reloading needs a reset
            ram_full_nxt = 1'b1;
          end else begin
            ram_addr_nxt = ram_addr_r + 16'h0001;
          end
          state_nxt = PRL_ST_POLL;
        end
      end
      PRL_ST_JUMP: begin
        // hand over at entry address
        // jump_out stands one cycle, then done holds until reset
        jump_nxt  = 1'b1;
        state_nxt = PRL_ST_DONE;
      end
      default: begin
        // done: nothing left to do until reset
      end
    endcase
  end

  // clock enable low freezes every register of the loader
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r     <= PRL_ST_START;
      start_cnt_r <= 8'h00;
      src_r       <= SRC_RESET;
      ram_addr_r  <= RAM_ENTRY_ADDR;
      ram_full_r  <= 1'b0;
      wr_r        <= '0;
      hs_out_r    <= 1'b0;
      jump_r      <= 1'b0;
      flash_cnt_r <= 25'h0000000;
      red_r       <= 1'b0;
      rom_dis_r   <= 1'b0;
    end else if (clk_en_in) begin
      state_r     <= state_nxt;
      start_cnt_r <= start_cnt_nxt;
      src_r       <= src_nxt;
      ram_addr_r  <= ram_addr_nxt;
      ram_full_r  <= ram_full_nxt;
      wr_r        <= wr_nxt;
      hs_out_r    <= hs_out_nxt;
      jump_r      <= jump_nxt;
      flash_cnt_r <= flash_cnt_nxt;
      red_r       <= red_nxt;
      rom_dis_r   <= rom_dis_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign handshake_output_out     = hs_out_r;
  assign src_addr_out             = {{(SRC_ADDR_W - SRC_LOW_W){1'b0}}, src_r};
  assign external_rom_disable_out = rom_dis_r;
  assign ram_wr_out               = wr_r;
  assign red_led_out              = red_r;
  assign green_led_out            = 1'b0;
  assign jump_out                 = jump_r;
  assign jump_addr_out            = RAM_ENTRY_ADDR;
  // busy is decoded from state, so it leads the registered outputs
  assign loading_out              = (state_r == PRL_ST_POLL) || (state_r == PRL_ST_WAIT_ACK)
                                    || (state_r == PRL_ST_RELEASE);
endmodule : prl_ram_boot_loader

// ### tb/prl_checker.sv
// port assertions of the parallel ram boot loader
`timescale 1ns/1ns
module prl_checker
  import prl_pkg::*;
(
  input wire logic        core_clk_in,              // clock
  input wire logic        reset_n_in,               // reset
  input wire logic        user_rom_disable_in,      // program level
  input wire logic        handshake_output_out,     // request
  input wire logic [13:0] src_addr_out,             // source address
  input wire logic        external_rom_disable_out, // eprom off
  input wire prl_ram_wr_t ram_wr_out,               // ram write
  input wire logic        red_led_out,              // red
  input wire logic        green_led_out,            // green
  input wire logic        jump_out,                 // jump pulse
  input wire logic [15:0] jump_addr_out,            // jump target
  input wire logic        loading_out               // busy
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_green_off: assert property (!green_led_out) else $error("green lit");
  a_red_idle: assert property (loading_out |-> !red_led_out) else $error("red lit");
  a_high_zero: assert property (src_addr_out[13:8] == 6'h00) else $error("high addr");
  a_jump_target: assert property (jump_out |-> jump_addr_out == 16'h0050)
    else $error("jump target");
  a_jump_pulse: assert property (jump_out |=> !jump_out ##1 !jump_out) else $error("jump len");
  a_wr_drops_req: assert property (ram_wr_out.we |-> $fell(handshake_output_out))
    else $error("request held");
  a_wr_ascend: assert property (ram_wr_out.we |->
    ram_wr_out.addr == 16'h0050 + {8'h00, src_addr_out[7:0]}) else $error("addr");
  a_wr_busy: assert property (ram_wr_out.we |-> loading_out) else $error("idle write");
  a_lock_quiet: assert property (red_led_out |-> !handshake_output_out && !loading_out)
    else $error("locked run");
  a_rom_disable: assert property (external_rom_disable_out |->
    $past(user_rom_disable_in) && !loading_out) else $error("rom off");
  c_write: cover property (ram_wr_out.we);
  c_jump: cover property (jump_out);
  c_flash: cover property ($rose(red_led_out));
endmodule : prl_checker

bind prl_ram_boot_loader prl_checker i_prl_checker (
  .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .user_rom_disable_in(user_rom_disable_in), .handshake_output_out(handshake_output_out),
  .src_addr_out(src_addr_out), .external_rom_disable_out(external_rom_disable_out),
  .ram_wr_out(ram_wr_out), .red_led_out(red_led_out), .green_led_out(green_led_out),
  .jump_out(jump_out), .jump_addr_out(jump_addr_out), .loading_out(loading_out));

// ### tb/prl_src_model.sv
// behavioural byte source answering the request handshake
`timescale 1ns/1ns
module prl_src_model (
  input  wire logic        clk_in,   // clock
  input  wire logic        req_in,   // byte request
  input  wire logic [13:0] addr_in,  // source address
  input  wire logic [2:0]  img_in,   // image switches
  input  wire logic        slow_in,  // stretch answers
  output logic             ack_out,  // byte valid
  output logic [7:0]       data_out  // byte
);
  int wait_cnt;
  initial begin
    ack_out = 1'b0;
    data_out = 8'h00;
    wait_cnt = 0;
  end
  always @(posedge clk_in) begin
    #1;
    if (req_in === ack_out) wait_cnt = 0;
    else if (wait_cnt < (slow_in ? 6 : 0)) wait_cnt++;
    else begin
      ack_out = req_in;
      // released bus shows no stale byte
      data_out = req_in ? (addr_in[7:0] ^ {img_in, 5'h1a}) : ~data_out;
    end
  end
endmodule : prl_src_model

// ### tb/testbench.sv
// self-checking bench of the parallel ram boot loader
`timescale 1ns/1ns
module testbench;
  import prl_pkg::*;
  logic clk, rst_n, lock, stop, tie, slow, rom_dis, ack, hs_out, jmp, red, red_d, grn, xdis, ld;
  logic [2:0] img;
  logic en;
  logic [7:0] sdat, dat;
  logic [13:0] src;
  logic [15:0] jaddr;
  prl_ram_wr_t wr;
  int err_count, compares, wr_cnt, jmp_cnt, red_tg;
  function automatic logic [7:0] byte_of(input logic [7:0] i, input logic [2:0] m);
    return i ^ {m, 5'h1a};
  endfunction : byte_of
  // plain eprom: request looped to ack
  assign dat = tie ? byte_of(src[7:0], img) : sdat;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  prl_ram_boot_loader #(.FLASH_HALF(8)) i_prl_ram_boot_loader (
    .core_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en), .security_lock_bit_in(lock),
    .loader_stop_pin_in(stop), .handshake_input_in(tie ? hs_out : ack), .data_port_in(dat),
    .user_rom_disable_in(rom_dis), .handshake_output_out(hs_out), .src_addr_out(src),
    .external_rom_disable_out(xdis), .ram_wr_out(wr), .red_led_out(red),
    .green_led_out(grn), .jump_out(jmp), .jump_addr_out(jaddr), .loading_out(ld));
  prl_src_model i_prl_src_model (.clk_in(clk), .req_in(hs_out), .addr_in(src),
    .img_in(img), .slow_in(slow), .ack_out(ack), .data_out(sdat));
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  always @(posedge clk) begin
    if (rst_n && wr.we) begin
      chk(wr.addr, 16'h0050 + 16'(wr_cnt));
      chk({2'b00, src}, 16'(wr_cnt));
      chk({8'h00, wr.data}, {8'h00, byte_of(8'(wr_cnt), img)});
      wr_cnt++;
    end
    if (rst_n && jmp) begin
      jmp_cnt++;
      chk(jaddr, 16'h0050);
    end
    if (red !== red_d) red_tg++;
    red_d = red;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic go(input logic lk, input logic tl, input logic sl, input logic [2:0] im);
    step(1);
    rst_n = 1'b0;
    {lock, tie, slow, img, stop, rom_dis} = {lk, tl, sl, im, 2'b10};
    step(12);
    {wr_cnt, jmp_cnt} = '0;
    rst_n = 1'b1;
  endtask : go
  task automatic wait_until(input int n, input int nw);
    for (int i = 0; i < n && jmp_cnt == 0 && wr_cnt < nw; i++) step(1);
    if (jmp_cnt == 0 && wr_cnt < nw) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_until
  task automatic t_locked();
    go(1'b0, 1'b0, 1'b0, 3'h0);
    step(200);
    red_tg = 0;
    step(64);
    chk(16'(red_tg), 16'h0008);
    chk(16'(wr_cnt), 16'h0000);
    chk({15'h0, ld}, 16'h0000);
    chk({15'h0, grn}, 16'h0000);
  endtask : t_locked
  task automatic t_full();
    go(1'b1, 1'b0, 1'b0, 3'h5);
    wait_until(4000, 20);
    en = 1'b0;
    step(40);
    chk(16'(wr_cnt), 16'h0014);
    en = 1'b1;
    wait_until(4000, 999);
    chk(16'(wr_cnt), 16'h00b0);
    rom_dis = 1'b1;
    step(3);
    chk({15'h0, xdis}, 16'h0001);
  endtask : t_full
  task automatic t_stop(input logic tl, input logic sl, input int n);
    go(1'b1, tl, sl, 3'h2);
    wait_until(1000, n);
    stop = 1'b0;
    wait_until(200, 999);
    chk(16'(wr_cnt), 16'(n));
  endtask : t_stop
  task automatic t_imm();
    go(1'b1, 1'b0, 1'b1, 3'h7);
    step(START_CYCLES);
    stop = 1'b0;
    wait_until(100, 999);
    chk(16'(wr_cnt), 16'h0000);
    chk(16'(jmp_cnt), 16'h0001);
  endtask : t_imm
  initial begin
    {rst_n, lock, stop, tie, slow, img, rom_dis, red_d} = '0;
    {err_count, compares, red_tg} = '0;
    en = 1'b1;
    t_locked();
    t_full();
    t_stop(1'b0, 1'b1, 5);
    t_stop(1'b1, 1'b0, 3);
    t_imm();
    give_verdict();
  end
endmodule : testbench
